// ===== design/srp_sram_port.sv
`timescale 1ns/1ps
`default_nettype none
module srp_sram_port
  import srp_pkg::*;
#(
  parameter int ADDR_W = SRP_ADDR_W,
  parameter int LANES = SRP_LANES
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] address_in,
  input wire logic proc_addr_strobe_n_in,
  input wire logic ctrl_addr_strobe_n_in,
  input wire logic burst_advance_n_in,
  input wire logic global_write_n_in,
  input wire logic byte_write_enable_n_in,
  input wire logic [LANES-1:0] byte_lane_select_n_in,
  input wire logic chip_sel_one_n_in,
  input wire logic chip_sel_two_in,
  input wire logic chip_sel_three_n_in,
  input wire logic out_enable_n_in,
  input wire logic sleep_request_in,
  input wire logic burst_order_in,
  input wire logic [LANES*SRP_LANE_W-1:0] data_in,
  output logic [LANES*SRP_LANE_W-1:0] data_out,
  output logic data_oe_n_out,
  input wire logic [LANES-1:0] parity_io_in,
  output logic [LANES-1:0] parity_io_out,
  output logic parity_io_oe_n_out
);

  localparam int DEPTH = 1 << ADDR_W;
  localparam int UPPER_W = ADDR_W - SRP_BURST_W;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (ADDR_W <= SRP_BURST_W || LANES < 1) begin : g_bad_param
    $error("srp_sram_port: address must exceed burst bits, lanes at least one");
  end

  srp_state_t state;
  srp_state_t next_state;
  logic [UPPER_W-1:0] upper_addr;
  logic [SRP_BURST_W-1:0] beat_low;
  logic [SRP_BURST_W-1:0] next_low;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] eff_addr;
  logic [SRP_ASYNC_N-1:0] async_raw;
  logic [SRP_ASYNC_N-1:0] async_filt;
  logic oe_n_f;
  logic asleep;
  logic awake;
  logic interleave;
  logic strap_taken;
  logic sel_ok;
  logic proc_take;
  logic ctrl_take;
  logic strobe;
  logic start;
  logic desel;
  logic in_burst;
  logic advance;
  logic [LANES-1:0] lane_we;
  logic any_write;
  logic read_start;
  logic write_go;
  logic mask;
  logic next_mask;
  logic drive_n;
  logic next_drive_n;

  // ****************************************************************
  // Asynchronous pin synchronisers
  // ****************************************************************
  // Output enable and sleep come from outside the clock; a change
  // counts only once the second and third stages agree.
  assign async_raw[SRP_IDX_OE_N] = out_enable_n_in;
  assign async_raw[SRP_IDX_SLEEP] = sleep_request_in;

  for (genvar i = 0; i < SRP_ASYNC_N; i++) begin : g_sync
    logic [SRP_SYNC_STAGES-1:0] stg;
    logic filt;
    // Three stage shift, then agreement filter
    always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
        stg <= {SRP_SYNC_STAGES{SRP_ASYNC_RST[i]}};
        filt <= SRP_ASYNC_RST[i];
      end else begin
        stg <= {stg[SRP_SYNC_STAGES-2:0], async_raw[i]};
        if (stg[1] == stg[2]) begin
          filt <= stg[2];
        end
      end
    end
    assign async_filt[i] = filt;
  end

  assign oe_n_f = async_filt[SRP_IDX_OE_N];
  assign asleep = async_filt[SRP_IDX_SLEEP];
  assign awake = !asleep;

  // ****************************************************************
  // Burst order strap
  // ****************************************************************
  // Caught once after reset release; later changes are not followed
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_taken <= 1'h0;
      interleave <= SRP_MODE_RST;
    end else if (!strap_taken) begin
      strap_taken <= 1'h1;
      interleave <= (burst_order_in != SRP_MODE_LINEAR);
    end
  end

  // ****************************************************************
  // Selection and strobe decode
  // ****************************************************************
  assign sel_ok = !chip_sel_one_n_in && chip_sel_two_in && !chip_sel_three_n_in;
  assign proc_take = !proc_addr_strobe_n_in && !chip_sel_one_n_in;
  assign ctrl_take = !ctrl_addr_strobe_n_in && !proc_take;
  assign strobe = (proc_take || ctrl_take) && awake;
  assign start = strobe && sel_ok;
  assign desel = strobe && !sel_ok;
  assign in_burst = (state == SRP_BURST) && !strobe && awake;
  assign advance = in_burst && !burst_advance_n_in;

  // Lane write enables: global write overrides lane selects
  for (genvar l = 0; l < LANES; l++) begin : g_we
    assign lane_we[l] = !global_write_n_in
      || (!byte_write_enable_n_in && !byte_lane_select_n_in[l]);
  end
  assign any_write = |lane_we;

  // A processor strobe always opens a read; controller strobe may write
  assign read_start = start && (proc_take || !any_write);
  assign write_go = awake && ((start && ctrl_take) || in_burst);

  // ****************************************************************
  // Burst address sequencer
  // ****************************************************************
  srp_burst_seq u_burst (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .load_in(start),
    .advance_in(advance),
    .start_low_in(address_in[SRP_BURST_W-1:0]),
    .interleave_in(interleave),
    .beat_low_out(beat_low),
    .next_low_out(next_low)
  );

  // Upper bits held for the whole burst, low bits from the counter
  assign cur_addr = {upper_addr, beat_low};
  assign eff_addr = start ? address_in : (advance ? {upper_addr, next_low} : cur_addr);

  // ****************************************************************
  // Control state
  // ****************************************************************
  assign next_state = start ? SRP_BURST : (desel ? SRP_IDLE : state);
  assign next_mask = read_start && (state == SRP_IDLE);
  assign next_drive_n = oe_n_f || (next_state != SRP_BURST) || next_mask || asleep;

  // State, address register and output drive enable
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= SRP_IDLE;
      upper_addr <= '0;
      mask <= 1'h0;
      drive_n <= SRP_DRIVE_N_RST;
    end else begin
      state <= next_state;
      mask <= next_mask;
      drive_n <= next_drive_n;
      if (start) begin
        upper_addr <= address_in[ADDR_W-1:SRP_BURST_W];
      end
    end
  end

  assign data_oe_n_out = drive_n;
  assign parity_io_oe_n_out = drive_n;

  // ****************************************************************
  // Storage and output registers, one slice per byte lane
  // ****************************************************************
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [SRP_LANE_W:0] cells [DEPTH];
    logic [SRP_LANE_W:0] rd_q;
    // Lane storage, no reset so contents survive sleep
    always_ff @(posedge core_clk_in) begin
      if (write_go && lane_we[l]) begin
        cells[eff_addr] <= {parity_io_in[l], data_in[l*SRP_LANE_W +: SRP_LANE_W]};
      end
    end
    // Output register: one cycle behind the address register
    always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
        rd_q <= SRP_LANE_RST;
      end else if (awake) begin
        rd_q <= cells[cur_addr];
      end
    end
    assign data_out[l*SRP_LANE_W +: SRP_LANE_W] = rd_q[SRP_LANE_W-1:0];
    assign parity_io_out[l] = rd_q[SRP_LANE_W];
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  addr_capture_a: assert property (start |=>
    (upper_addr == $past(address_in[ADDR_W-1:SRP_BURST_W]) && state == SRP_BURST))
    else $error("selected strobe did not capture address");
  addr_hold_a: assert property ((state == SRP_BURST && !start) |=> $stable(upper_addr))
    else $error("upper address moved inside a burst");
  counter_seed_a: assert property (start |=> beat_low == $past(address_in[SRP_BURST_W-1:0]))
    else $error("burst counter not seeded");
  lane_gate_a: assert property ((global_write_n_in && byte_write_enable_n_in) |->
    lane_we == '0)
    else $error("lane write without byte enable");
  global_all_a: assert property (!global_write_n_in |-> &lane_we)
    else $error("global write missed a lane");
  deselect_a: assert property ((strobe && !sel_ok) |=> (state == SRP_IDLE && drive_n))
    else $error("bad select combination did not deselect");
  proc_ignore_a: assert property ((chip_sel_one_n_in && ctrl_addr_strobe_n_in) |=>
    ($stable(state) && $stable(upper_addr)))
    else $error("processor strobe acted with select one high");
  proc_first_a: assert property ((!proc_addr_strobe_n_in && !ctrl_addr_strobe_n_in
    && !chip_sel_one_n_in && sel_ok && awake && !global_write_n_in) |-> !write_go
    ##1 (state == SRP_BURST && mask == $past(state == SRP_IDLE)))
    else $error("dual strobe not treated as processor read");
  oe_off_a: assert property ((oe_n_f && !rst_in) |=> data_oe_n_out)
    else $error("pins driven with output enable high");
  first_mask_a: assert property ((read_start && state == SRP_IDLE) |=>
    (data_oe_n_out && parity_io_oe_n_out))
    else $error("first read clock after deselect was driven");
  sleep_hold_a: assert property (asleep |=>
    ($stable(state) && data_oe_n_out && $stable(data_out)))
    else $error("activity while asleep");

  read_cold_c: cover property ((read_start && state == SRP_IDLE) ##1 !oe_n_f ##1 !data_oe_n_out);
  burst_four_c: cover property (start ##1 advance [*4]);
  global_wr_c: cover property (write_go && !global_write_n_in);
  sleep_c: cover property ((state == SRP_BURST) ##1 asleep);

endmodule
`default_nettype wire

// ===== design/srp_pkg.sv
`default_nettype none
// ****************************************************************
// Shared constants of the pipelined synchronous memory port
// ****************************************************************
package srp_pkg;

  // Geometry: 128K words of four lanes, each eight data and one parity bit
  localparam int SRP_ADDR_W = 17;
  localparam int SRP_LANES = 4;
  localparam int SRP_LANE_W = 8;

  // Burst counter width, taken from the lowest address bits
  localparam int SRP_BURST_W = 2;
  localparam logic [1:0] SRP_BEAT_ONE = 2'h1;
  localparam logic [1:0] SRP_BEAT_LAST = 2'h3;
  localparam logic [1:0] SRP_BEAT_RST = 2'h0;

  // Burst order strap encoding and the order assumed until it is caught
  localparam logic SRP_MODE_LINEAR = 1'h0;
  localparam logic SRP_MODE_RST = 1'h1;

  // Asynchronous pin synchroniser: stage count and reset level per pin
  localparam int SRP_SYNC_STAGES = 3;
  localparam int SRP_ASYNC_N = 2;
  localparam int SRP_IDX_OE_N = 0;
  localparam int SRP_IDX_SLEEP = 1;
  localparam logic [SRP_ASYNC_N-1:0] SRP_ASYNC_RST = 2'h1;

  // Output driver enable, active low, idle value
  localparam logic SRP_DRIVE_N_RST = 1'h1;
  localparam logic [SRP_LANE_W:0] SRP_LANE_RST = 9'h000;

  // Port state: deselected, or inside a selected access or burst
  typedef enum logic [0:0] {
    SRP_IDLE = 1'b0,
    SRP_BURST = 1'b1
  } srp_state_t;

endpackage
`default_nettype wire

// ===== design/srp_burst_seq.sv
`timescale 1ns/1ps
`default_nettype none
module srp_burst_seq
  import srp_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic advance_in,
  input wire logic [SRP_BURST_W-1:0] start_low_in,
  input wire logic interleave_in,
  output logic [SRP_BURST_W-1:0] beat_low_out,
  output logic [SRP_BURST_W-1:0] next_low_out
);

  logic [SRP_BURST_W-1:0] start_q;
  logic [SRP_BURST_W-1:0] cnt;
  logic [SRP_BURST_W-1:0] next_cnt;

  // Beat address from start bits and count, in either burst order
  function automatic logic [SRP_BURST_W-1:0] beat_of(
    input logic [SRP_BURST_W-1:0] s,
    input logic [SRP_BURST_W-1:0] c,
    input logic il
  );
    beat_of = il ? (s ^ c) : SRP_BURST_W'(s + c);
  endfunction

  // Counter wraps inside two bits, never carrying upward
  assign next_cnt = SRP_BURST_W'(cnt + SRP_BEAT_ONE);
  assign beat_low_out = beat_of(start_q, cnt, interleave_in);
  assign next_low_out = beat_of(start_q, next_cnt, interleave_in);

  // ****************************************************************
  // Burst counter
  // ****************************************************************
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      start_q <= SRP_BEAT_RST;
      cnt <= SRP_BEAT_RST;
    end else if (load_in) begin
      start_q <= start_low_in;
      cnt <= SRP_BEAT_RST;
    end else if (advance_in) begin
      cnt <= next_cnt;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  burst_load_a: assert property (load_in |=> beat_low_out == $past(start_low_in))
    else $error("burst start bits not loaded");
  burst_step_a: assert property ((advance_in && !load_in) |=>
    cnt == SRP_BURST_W'($past(cnt) + SRP_BEAT_ONE))
    else $error("burst counter did not step");
  burst_wrap_a: assert property ((advance_in && !load_in && cnt == SRP_BEAT_LAST) |=>
    (beat_low_out == start_q && $stable(start_q)))
    else $error("burst did not wrap to start");
  beat_order_a: assert property ((cnt == SRP_BEAT_ONE) |->
    beat_low_out == (interleave_in ? (start_q ^ SRP_BEAT_ONE)
                                    : SRP_BURST_W'(start_q + SRP_BEAT_ONE)))
    else $error("second beat address wrong");

endmodule
`default_nettype wire

// ===== test/srp_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bus master standing on the far side of the port
// ****************************************
module srp_bus_master
  import srp_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  input wire logic core_clk_in,
  output logic [ADDR_W-1:0] address_out,
  output logic proc_strobe_n_out,
  output logic ctrl_strobe_n_out,
  output logic advance_n_out,
  output logic global_write_n_out,
  output logic byte_write_enable_n_out,
  output logic [SRP_LANES-1:0] lane_select_n_out,
  output logic [2:0] sel_out,
  output logic [SRP_LANES*SRP_LANE_W-1:0] data_out,
  output logic [SRP_LANES-1:0] parity_out
);
  // Quiet bus at time zero
  initial begin
    {proc_strobe_n_out, ctrl_strobe_n_out, advance_n_out} = 3'h7;
    {global_write_n_out, byte_write_enable_n_out} = 2'h3;
    lane_select_n_out = 4'hF;
    sel_out = 3'h2;
    address_out = '0;
    {parity_out, data_out} = 36'h0;
  end

  // Present one request and hold it through the sampling edge
  task automatic put(input logic [2:0] ctl, input logic [1:0] wr, input logic [3:0] lanes,
    input logic [2:0] sel, input logic [ADDR_W-1:0] addr, input logic [35:0] word);
    {proc_strobe_n_out, ctrl_strobe_n_out, advance_n_out} = ctl;
    {global_write_n_out, byte_write_enable_n_out} = wr;
    lane_select_n_out = lanes;
    sel_out = sel;
    address_out = addr;
    {parity_out, data_out} = word;
    @(posedge core_clk_in);
    #1;
  endtask

  // Selected but no request; released data lines flip every cycle
  task automatic idle();
    {proc_strobe_n_out, ctrl_strobe_n_out, advance_n_out} = 3'h7;
    {global_write_n_out, byte_write_enable_n_out} = 2'h3;
    lane_select_n_out = 4'hF;
    sel_out = 3'h2;
    data_out = ~data_out;
    parity_out = ~parity_out;
    @(posedge core_clk_in);
    #1;
  endtask
endmodule
`default_nettype wire

// ===== test/pipelined_sync_sram_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module pipelined_sync_sram_port_test
  import srp_pkg::*;
;
  localparam int AW = 6;
  localparam logic [2:0] SEL_OK = 3'h2;
  logic core_clk_in, rst_in, out_enable_n_in, sleep_request_in, burst_order_in;
  logic [AW-1:0] addr;
  logic ps_n, cs_n, adv_n, gw_n, bwe_n, d_oe_n, p_oe_n;
  logic [3:0] ln_n, p_w, p_r;
  logic [2:0] sel;
  logic [31:0] d_w, d_r;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  // ****************************************
  // Design, its bus master and the clock
  // ****************************************
  srp_sram_port #(.ADDR_W(AW), .LANES(4)) i_dut (.core_clk_in(core_clk_in),
    .rst_in(rst_in), .address_in(addr), .proc_addr_strobe_n_in(ps_n),
    .ctrl_addr_strobe_n_in(cs_n), .burst_advance_n_in(adv_n), .global_write_n_in(gw_n),
    .byte_write_enable_n_in(bwe_n), .byte_lane_select_n_in(ln_n),
    .chip_sel_one_n_in(sel[2]), .chip_sel_two_in(sel[1]), .chip_sel_three_n_in(sel[0]),
    .out_enable_n_in(out_enable_n_in), .sleep_request_in(sleep_request_in),
    .burst_order_in(burst_order_in), .data_in(d_w), .data_out(d_r), .data_oe_n_out(d_oe_n),
    .parity_io_in(p_w), .parity_io_out(p_r), .parity_io_oe_n_out(p_oe_n));

  srp_bus_master #(.ADDR_W(AW)) i_master (.core_clk_in(core_clk_in), .address_out(addr),
    .proc_strobe_n_out(ps_n), .ctrl_strobe_n_out(cs_n), .advance_n_out(adv_n),
    .global_write_n_out(gw_n), .byte_write_enable_n_out(bwe_n), .lane_select_n_out(ln_n),
    .sel_out(sel), .data_out(d_w), .parity_out(p_w));

  // Free running clock
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  // Hang guard
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [35:0] word_of(input int k);
    return {4'(k), 32'hC0DE0000 + 32'(k)};
  endfunction

  task automatic do_reset(input logic il);
    rst_in = 1'b1;
    burst_order_in = il;
    repeat (10) @(posedge core_clk_in);
    #1;
    rst_in = 1'b0;
    repeat (8) @(posedge core_clk_in);
    #1;
  endtask

  // Read one word; with both strobes low the write controls are live too
  task automatic rd(input logic [AW-1:0] a, input logic both, input logic [35:0] exp,
    input logic first_oe_exp, input logic oe_exp);
    i_master.put({1'b0, !both, 1'b1}, both ? 2'h0 : 2'h3, 4'h0, SEL_OK, a, 36'h0);
    chk({35'h0, d_oe_n}, {35'h0, first_oe_exp});
    i_master.idle();
    chk({p_r, d_r}, exp);
    chk({35'h0, d_oe_n}, {35'h0, oe_exp});
    chk({35'h0, p_oe_n}, {35'h0, oe_exp});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic burst_chk(input logic il);
    logic [AW-1:0] base;
    base = 6'h2E;
    i_master.put(3'h5, 2'h1, 4'hF, SEL_OK, base, word_of(0));
    for (int k = 1; k <= 4; k++) begin
      i_master.put(3'h6, 2'h1, 4'hF, SEL_OK, ~base, word_of(k));
    end
    i_master.idle();
    for (int k = 1; k <= 4; k++) begin
      rd({base[AW-1:2], il ? base[1:0] ^ 2'(k) : base[1:0] + 2'(k)}, 1'b0, word_of(k),
        1'b0, 1'b0);
    end
  endtask

  task automatic lanes_chk();
    i_master.put(3'h5, 2'h1, 4'hF, SEL_OK, 6'h09, 36'hF_FFFF_FFFF);
    i_master.put(3'h5, 2'h2, 4'hA, SEL_OK, 6'h09, 36'h0);
    i_master.put(3'h5, 2'h3, 4'h0, SEL_OK, 6'h09, 36'h0);
    i_master.idle();
    rd(6'h09, 1'b1, 36'hA_FF00_FF00, 1'b0, 1'b0);
    rd(6'h09, 1'b0, 36'hA_FF00_FF00, 1'b0, 1'b0);
  endtask

  task automatic sleep_chk();
    i_master.put(3'h5, 2'h1, 4'hF, SEL_OK, 6'h15, 36'h3_0000_1111);
    sleep_request_in = 1'b1;
    repeat (6) i_master.idle();
    chk({35'h0, d_oe_n}, 36'h1);
    i_master.put(3'h5, 2'h1, 4'hF, SEL_OK, 6'h15, 36'h0);
    sleep_request_in = 1'b0;
    repeat (6) i_master.idle();
    i_master.put(3'h5, 2'h3, 4'hF, 3'h0, 6'h15, 36'h0);
    rd(6'h15, 1'b0, 36'h3_0000_1111, 1'b1, 1'b0);
  endtask

  task automatic desel_chk();
    logic [2:0] bad [3];
    bad = '{3'h6, 3'h0, 3'h3};
    i_master.put(3'h5, 2'h1, 4'hF, SEL_OK, 6'h15, 36'h5_1234_5678);
    // Processor strobe with select one high must not deselect the open access
    i_master.put(3'h3, 2'h3, 4'hF, 3'h6, 6'h15, 36'h0);
    chk({35'h0, d_oe_n}, 36'h0);
    foreach (bad[i]) begin
      i_master.put(3'h5, 2'h1, 4'hF, bad[i], 6'h15, 36'h0);
    end
    i_master.idle();
    chk({35'h0, d_oe_n}, 36'h1);
    rd(6'h15, 1'b0, 36'h5_1234_5678, 1'b1, 1'b0);
    rd(6'h15, 1'b0, 36'h5_1234_5678, 1'b0, 1'b0);
    out_enable_n_in = 1'b1;
    repeat (6) i_master.idle();
    rd(6'h15, 1'b0, 36'h5_1234_5678, 1'b1, 1'b1);
    out_enable_n_in = 1'b0;
    repeat (6) i_master.idle();
  endtask

  task automatic tally_and_finish();
    $display("Checks made: %0d, mismatches: %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence: linear order first, then interleaved after a fresh reset
  initial begin
    out_enable_n_in = 1'b0;
    sleep_request_in = 1'b0;
    do_reset(1'b0);
    burst_chk(1'b0);
    lanes_chk();
    sleep_chk();
    desel_chk();
    do_reset(1'b1);
    burst_chk(1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
